// File: logic/serial_host_register_port.sv
// spi read path and two-wire slave for host register access
`timescale 1ns/10ps
`include "shrp_cfg.svh"

module serial_host_register_port
  import shrp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic spiSelN,
  input wire logic spiDataIn,
  output logic spiDataOut,
  output logic spiDataOutEn,
  input wire logic i2cClkIn,
  output logic i2cClkOut,
  output logic i2cClkOutEn,
  input wire logic i2cDataIn,
  output logic i2cDataOut,
  output logic i2cDataOutEn,
  input wire logic addrSelectLow,
  input wire logic addrSelectHigh,
  output logic [9:0] regAddr,
  output logic regRdStrobe,
  input wire logic [15:0] regRdData,
  output logic wrValid,
  input wire logic wrReady,
  output shrp_wr_type wrWord
);

  // pointer step that freezes at the top
  function automatic logic [9:0] ptrStep(input logic [9:0] p);
    ptrStep = (p == `SHRP_PTR_MAX) ? p : 10'(p + 10'h001);
  endfunction : ptrStep

  // pin synchronisers: first stage read only by the second
  logic spiClkS1_r, spiClkS2_r, spiClkD_r;
  logic spiSelS1_r, spiSelS2_r;
  logic spiDinS1_r, spiDinS2_r;
  logic sclS1_r, sclS2_r, sclD_r;
  logic sdaS1_r, sdaS2_r, sdaD_r;
  logic selLoS1_r, selLoS2_r;
  logic selHiS1_r, selHiS2_r;

  always_ff @(posedge clk_sys) begin
    spiClkS1_r <= spiClk;
    spiClkS2_r <= spiClkS1_r;
    spiSelS1_r <= spiSelN;
    spiSelS2_r <= spiSelS1_r;
    spiDinS1_r <= spiDataIn;
    spiDinS2_r <= spiDinS1_r;
    sclS1_r <= i2cClkIn;
    sclS2_r <= sclS1_r;
    sdaS1_r <= i2cDataIn;
    sdaS2_r <= sdaS1_r;
    selLoS1_r <= addrSelectLow;
    selLoS2_r <= selLoS1_r;
    selHiS1_r <= addrSelectHigh;
    selHiS2_r <= selHiS1_r;
  end

  // edge history, taken from the second stage only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spiClkD_r <= 1'b0;
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      spiClkD_r <= spiClkS2_r;
      sclD_r <= sclS2_r;
      sdaD_r <= sdaS2_r;
    end
  end

  // edge and condition decode
  wire spiSel = ~spiSelS2_r;
  wire spiRise = spiClkS2_r & ~spiClkD_r; // sample edge
  wire spiFall = ~spiClkS2_r & spiClkD_r; // drive edge
  wire sclRise = sclS2_r & ~sclD_r;
  wire sclFall = ~sclS2_r & sclD_r;
  // data moving while clock high marks start or stop
  wire startCond = sclS2_r & sclD_r & ~sdaS2_r & sdaD_r;
  wire stopCond = sclS2_r & sclD_r & sdaS2_r & ~sdaD_r;
  wire [6:0] ownAddr = {`SHRP_I2C_ADDR_HI, selHiS2_r, selLoS2_r};

  // spi state
  logic [14:0] cmd_r; // command bits shifted so far
  logic [3:0] spiCnt_r; // command bit count
  logic spiRead_r; // read data phase active
  logic spiKick_r; // first word request pending
  logic [15:0] spiSh_r; // outgoing word
  logic [3:0] outCnt_r; // bits driven of current word
  logic spiOut_r;
  logic spiOe_r;
  wire [15:0] spiWord = {cmd_r, spiDinS2_r};
  // enable pattern and read direction seen
  wire cmdIsRead = (spiWord[15:11] == `SHRP_SPI_ENABLE)
    && (spiWord[10] == `SHRP_SPI_DIR_READ);
  wire cmdDone = spiRise & ~spiRead_r & (spiCnt_r == `SHRP_SPI_LAST_BIT);
  // next word fetched as the sixteenth bit goes out
  wire spiReq = spiKick_r
    | (spiRead_r & spiFall & (outCnt_r == `SHRP_SPI_LAST_BIT));

  // two-wire state
  shrp_i2c_state_type st_r;
  logic [3:0] bitCnt_r; // bits of current byte
  logic [7:0] rxByte_r; // received byte
  logic [7:0] txByte_r; // byte being sent, remaining bits
  logic addrPhase_r; // next byte is an address
  logic isRead_r; // direction of current transfer
  logic [1:0] byteIdx_r; // position of write byte
  logic [1:0] ptrHi_r; // pointer bits 9:8 held
  logic [7:0] dataHi_r; // upper data byte held
  logic loHalf_r; // next byte to send is the low half
  logic [15:0] rdWord_r; // word being read out
  logic sdaOe_r; // pulling data line low
  logic pendWr_r; // write word waiting for the buffer
  logic wrEnd_r; // write made at top, later data dropped
  shrp_wr_type wrHold_r;

  wire byteDone = (st_r == ST_RECV) & sclFall
    & (bitCnt_r == `SHRP_I2C_LAST_BIT);
  wire addrHit = (rxByte_r[7:1] == ownAddr);
  wire dataByte = byteDone & ~addrPhase_r;
  wire ptrLoad = dataByte & (byteIdx_r == 2'h1);
  wire wrFire = dataByte & (byteIdx_r == 2'h3) & ~wrEnd_r;
  wire [7:0] nextByte = loHalf_r ? rdWord_r[7:0] : rdWord_r[15:8];
  // read request on a matching read address or an acked low byte
  wire i2cReq = (byteDone & addrPhase_r & addrHit & rxByte_r[0])
    | ((st_r == ST_MACK) & sclRise & ~sdaS2_r & ~loHalf_r);

  // shared pointer and register read port
  logic [9:0] ptr_r;
  logic regRdStrobe_r;
  logic [9:0] regAddr_r;
  logic rdToSpi_r;
  logic loadCycle_r;
  logic bufInReady;
  wire rdReq = spiReq | i2cReq;
  wire wrPush = pendWr_r & bufInReady;

  // pointer: stop clears, command or pointer bytes load, use steps
  always_ff @(posedge clk_sys) begin
    if (rst || stopCond) begin
      ptr_r <= `SHRP_PTR_RESET;
    end else if (cmdDone && cmdIsRead) begin
      ptr_r <= spiWord[9:0];
    end else if (ptrLoad) begin
      ptr_r <= {ptrHi_r, rxByte_r};
    end else if (rdReq || wrFire) begin
      ptr_r <= ptrStep(ptr_r);
    end
  end

  // read strobe one cycle after request, data the cycle after
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdStrobe_r <= 1'b0;
      regAddr_r <= `SHRP_PTR_RESET;
      rdToSpi_r <= 1'b0;
      loadCycle_r <= 1'b0;
    end else begin
      regRdStrobe_r <= rdReq;
      loadCycle_r <= regRdStrobe_r;
      if (rdReq) begin
        regAddr_r <= ptr_r;
        rdToSpi_r <= spiReq;
      end
    end
  end

  // spi command and read shifter, cleared while deselected
  always_ff @(posedge clk_sys) begin
    if (rst || !spiSel) begin
      cmd_r <= '0;
      spiCnt_r <= 4'h0;
      spiRead_r <= 1'b0; // read ends with chip select
      spiKick_r <= 1'b0;
      outCnt_r <= 4'h0;
      spiOut_r <= 1'b0;
      spiOe_r <= 1'b0; // released when idle
    end else begin
      spiKick_r <= cmdDone & cmdIsRead;
      if (spiRise && !spiRead_r) begin
        // command bits; write commands are not served here
        cmd_r <= spiWord[14:0];
        spiCnt_r <= 4'(spiCnt_r + 4'h1);
        spiRead_r <= cmdDone & cmdIsRead;
      end
      if (spiRead_r && spiFall) begin
        // first falling after the command drives the msb
        spiOut_r <= spiSh_r[15];
        spiOe_r <= 1'b1;
        outCnt_r <= 4'(outCnt_r + 4'h1);
      end
    end
  end

  // outgoing spi word: load from register port, else shift
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      spiSh_r <= '0;
    end else if (loadCycle_r && rdToSpi_r) begin
      spiSh_r <= regRdData;
    end else if (spiRead_r && spiFall) begin
      spiSh_r <= {spiSh_r[14:0], 1'b0};
    end
  end

  // two-wire slave: reacts only to the master's conditions
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_IDLE;
      bitCnt_r <= 4'h0;
      rxByte_r <= 8'h00;
      txByte_r <= 8'h00;
      addrPhase_r <= 1'b0;
      isRead_r <= 1'b0;
      byteIdx_r <= 2'h0;
      ptrHi_r <= 2'h0;
      dataHi_r <= 8'h00;
      loHalf_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else if (startCond) begin
      // start or repeated start: expect an address
      st_r <= ST_RECV;
      bitCnt_r <= 4'h0;
      addrPhase_r <= 1'b1;
      sdaOe_r <= 1'b0;
    end else if (stopCond) begin
      st_r <= ST_IDLE;
      sdaOe_r <= 1'b0;
      byteIdx_r <= 2'h0;
    end else begin
      case (st_r)
        ST_RECV: begin
          if (sclRise && bitCnt_r != `SHRP_I2C_LAST_BIT) begin
            rxByte_r <= {rxByte_r[6:0], sdaS2_r}; // msb first
            bitCnt_r <= 4'(bitCnt_r + 4'h1);
          end else if (byteDone && addrPhase_r) begin
            if (addrHit) begin
              sdaOe_r <= 1'b1; // acknowledge
              st_r <= ST_ACK;
              isRead_r <= rxByte_r[0];
              addrPhase_r <= 1'b0;
              byteIdx_r <= 2'h0;
              loHalf_r <= 1'b0;
            end else begin
              st_r <= ST_IGNORE; // not ours
            end
          end else if (byteDone) begin
            sdaOe_r <= 1'b1;
            st_r <= ST_ACK;
            case (byteIdx_r)
              2'h0: begin
                ptrHi_r <= rxByte_r[1:0]; // upper six ignored
                byteIdx_r <= 2'h1;
              end
              2'h1: byteIdx_r <= 2'h2;
              2'h2: begin
                dataHi_r <= rxByte_r;
                byteIdx_r <= 2'h3;
              end
              default: byteIdx_r <= 2'h2; // next register pair
            endcase
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            if (isRead_r) begin
              // first read bit driven in the clock-low phase
              st_r <= ST_SEND;
              sdaOe_r <= ~nextByte[7];
              txByte_r <= {nextByte[6:0], 1'b0};
              bitCnt_r <= 4'h1;
              loHalf_r <= ~loHalf_r;
            end else begin
              st_r <= ST_RECV;
              sdaOe_r <= 1'b0;
              bitCnt_r <= 4'h0;
            end
          end
        end
        ST_SEND: begin
          if (sclFall) begin
            if (bitCnt_r == `SHRP_I2C_LAST_BIT) begin
              sdaOe_r <= 1'b0; // let master acknowledge
              st_r <= ST_MACK;
            end else begin
              sdaOe_r <= ~txByte_r[7];
              txByte_r <= {txByte_r[6:0], 1'b0};
              bitCnt_r <= 4'(bitCnt_r + 4'h1);
            end
          end
        end
        ST_MACK: begin
          if (sclRise && sdaS2_r) begin
            st_r <= ST_IGNORE; // not-acknowledge: wait for stop
          end else if (sclFall) begin
            st_r <= ST_SEND;
            sdaOe_r <= ~nextByte[7];
            txByte_r <= {nextByte[6:0], 1'b0};
            bitCnt_r <= 4'h1;
            loHalf_r <= ~loHalf_r;
          end
        end
        ST_IGNORE: sdaOe_r <= 1'b0;
        default: sdaOe_r <= 1'b0;
      endcase
    end
  end

  // read word for the two-wire side
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdWord_r <= '0;
    end else if (loadCycle_r && !rdToSpi_r) begin
      rdWord_r <= regRdData;
    end
  end

  // write word held until the buffer takes it; clock held low while that held word finds the buffer full
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pendWr_r <= 1'b0;
      wrEnd_r <= 1'b0;
      wrHold_r <= '0;
    end else begin
      if (wrFire) begin
        pendWr_r <= 1'b1;
        wrHold_r <= '{addr: ptr_r, data: {dataHi_r, rxByte_r}};
      end else if (wrPush) begin
        pendWr_r <= 1'b0;
      end
      if (stopCond || ptrLoad) begin
        wrEnd_r <= 1'b0;
      end else if (wrFire && ptr_r == `SHRP_PTR_MAX) begin
        wrEnd_r <= 1'b1; // top written once, rest dropped
      end
    end
  end

  shrp_wr_buf u_wr_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .inValid(pendWr_r),
    .inReady(bufInReady),
    .inWord(wrHold_r),
    .outValid(wrValid),
    .outReady(wrReady),
    .outWord(wrWord)
  );

  // pin and port drive
  assign spiDataOut = spiOut_r;
  assign spiDataOutEn = spiOe_r;
  assign i2cDataOut = 1'b0;
  assign i2cDataOutEn = sdaOe_r;
  assign i2cClkOut = 1'b0;
  // stretch only while the waiting word finds the buffer full
  assign i2cClkOutEn = pendWr_r & ~bufInReady;
  assign regAddr = regAddr_r;
  assign regRdStrobe = regRdStrobe_r;
endmodule : serial_host_register_port

// File: logic/shrp_cfg.svh
// constants of the serial host register port
`ifndef SHRP_CFG_SVH
`define SHRP_CFG_SVH
`define SHRP_SPI_ENABLE 5'h1C
`define SHRP_SPI_DIR_READ 1'h1
`define SHRP_SPI_LAST_BIT 4'hF
`define SHRP_I2C_ADDR_HI 5'h0B
`define SHRP_I2C_LAST_BIT 4'h8
`define SHRP_PTR_MAX 10'h3FF
`define SHRP_PTR_RESET 10'h000
`define SHRP_BUF_DEPTH 2'h2
`endif

// File: logic/shrp_pkg.sv
// types of the serial host register port
package shrp_pkg;
  // one register write: address and 16-bit word
  typedef struct packed {
    logic [9:0] addr;
    logic [15:0] data;
  } shrp_wr_type;
  // two-wire slave states
  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_IGNORE
  } shrp_i2c_state_type;
endpackage : shrp_pkg

// File: logic/shrp_wr_buf.sv
// two-entry buffer for register writes
`timescale 1ns/10ps
`include "shrp_cfg.svh"
module shrp_wr_buf
  import shrp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire shrp_wr_type inWord,
  output logic outValid,
  input wire logic outReady,
  output shrp_wr_type outWord
);
  shrp_wr_type ent0_r; // head entry, drives outWord
  shrp_wr_type ent1_r; // second entry
  logic [1:0] cnt_r; // entries held
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  // honest full and empty
  assign inReady = (cnt_r != `SHRP_BUF_DEPTH);
  assign outValid = (cnt_r != 2'h0);
  assign outWord = ent0_r;

  // entry storage and count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= 2'h0;
      ent0_r <= '0;
      ent1_r <= '0;
    end else begin
      if (pop) begin
        // shift the second entry forward, or take a fresh word
        ent0_r <= (push && cnt_r == 2'h1) ? inWord : ent1_r;
        if (push && cnt_r == 2'h2) begin
          ent1_r <= inWord;
        end
      end else if (push) begin
        if (cnt_r == 2'h0) begin
          ent0_r <= inWord;
        end else begin
          ent1_r <= inWord;
        end
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : shrp_wr_buf

// File: dv/shrp_port_sva.sv
// concurrent checks on the serial host register port pins
`timescale 1ns/10ps
module shrp_port_sva
  import shrp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic spiSelN,
  input wire logic spiDataOutEn,
  input wire logic i2cClkIn,
  input wire logic i2cClkOut,
  input wire logic i2cClkOutEn,
  input wire logic i2cDataOut,
  input wire logic i2cDataOutEn,
  input wire logic [9:0] regAddr,
  input wire logic regRdStrobe,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire shrp_wr_type wrWord
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_strobe_pulse:
    assert property (regRdStrobe |=> !regRdStrobe)
    else $error("read strobe longer than one cycle");
  a_spi_idle:
    assert property (spiSelN [*5] |-> !spiDataOutEn)
    else $error("spi output driven while deselected");
  a_ptr_step:
    assert property ($changed(regAddr) |-> regRdStrobe)
    else $error("read address moved without a read");
  a_ack_hold:
    assert property ($rose(i2cDataOutEn) |=> i2cDataOutEn [*6])
    else $error("data pull-down dropped early");
  a_data_move:
    assert property ($changed(i2cDataOutEn) |-> !i2cClkIn)
    else $error("data drive changed while clock high");
  a_open_drain:
    assert property (i2cDataOut == 1'h0 && i2cClkOut == 1'h0)
    else $error("open-drain pin driven high");
  a_stretch_low:
    assert property ($rose(i2cClkOutEn) |-> !i2cClkIn)
    else $error("clock pulled low while master held it high");
  a_stretch_full:
    assert property (i2cClkOutEn |-> wrValid)
    else $error("clock held with no write waiting");
  a_wr_hold:
    assert property (wrValid && !wrReady |=> wrValid && $stable(wrWord))
    else $error("write word lost while stalled");
endmodule : shrp_port_sva
bind serial_host_register_port shrp_port_sva chk (
  .clk_sys(clk_sys), .rst(rst), .spiSelN(spiSelN),
  .spiDataOutEn(spiDataOutEn), .i2cClkIn(i2cClkIn),
  .i2cClkOut(i2cClkOut), .i2cClkOutEn(i2cClkOutEn),
  .i2cDataOut(i2cDataOut), .i2cDataOutEn(i2cDataOutEn),
  .regAddr(regAddr), .regRdStrobe(regRdStrobe), .wrValid(wrValid),
  .wrReady(wrReady), .wrWord(wrWord));

// File: dv/shrp_host_model.sv
// serial bus master standing in for the host processor
`timescale 1ns/10ps
module shrp_host_model (
  input wire logic clk_sys,
  output logic spiClk,
  output logic spiSelN,
  output logic spiDataIn,
  input wire logic spiDataOut,
  output logic sclM,
  output logic sdaM,
  input wire logic scl,
  input wire logic sda
);
  // idle: select high, clocks high, data released
  initial begin
    spiClk = 1'h1;
    spiSelN = 1'h1;
    spiDataIn = 1'h0;
    sclM = 1'h1;
    sdaM = 1'h1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // one spi word: drive on falling, sample in the high phase
  task automatic spiWord(input logic [15:0] o, output logic [15:0] i);
    for (int k = 15; k >= 0; k--) begin
      spiClk <= 1'h0;
      spiDataIn <= o[k];
      cyc(4);
      spiClk <= 1'h1;
      cyc(2);
      i[k] = spiDataOut;
      cyc(2);
    end
  endtask : spiWord
  // command word then n read words, 16 clocks each
  task automatic spiRead(input logic [15:0] cmd, input int n,
                         output logic [63:0] w);
    logic [15:0] d;
    spiSelN <= 1'h0;
    cyc(4);
    spiWord(cmd, d);
    for (int j = 0; j < n; j++) begin
      spiWord(16'h0000, d);
      w[63 - 16 * j -: 16] = d;
    end
    cyc(4);
    spiSelN <= 1'h1;
    spiDataIn <= ~spiDataIn; // line flips once released
    cyc(8);
  endtask : spiRead
  // one bit; waits while the slave stretches the clock
  task automatic i2cBit(input logic b, output logic r);
    sdaM <= b;
    cyc(4);
    sclM <= 1'h1;
    cyc(2);
    while (!scl) cyc(1);
    cyc(4);
    r = sda;
    cyc(4);
    sclM <= 1'h0;
    cyc(4);
  endtask : i2cBit
  // start or repeated start
  task automatic i2cStart;
    sdaM <= 1'h1;
    cyc(4);
    sclM <= 1'h1;
    cyc(8);
    sdaM <= 1'h0;
    cyc(8);
    sclM <= 1'h0;
    cyc(4);
  endtask : i2cStart
  task automatic i2cStop;
    sdaM <= 1'h0;
    cyc(4);
    sclM <= 1'h1;
    cyc(8);
    sdaM <= 1'h1;
    cyc(8);
  endtask : i2cStop
  // eight bits msb first, then the ninth bit m (1 releases)
  task automatic i2cByte(input logic [7:0] b, input logic m,
                         output logic [7:0] r, output logic a);
    for (int k = 7; k >= 0; k--) i2cBit(b[k], r[k]);
    i2cBit(m, a);
  endtask : i2cByte
endmodule : shrp_host_model

// File: dv/serial_host_register_port_tb.sv
// self-checking bench for the serial host register port
`timescale 1ns/10ps
module serial_host_register_port_tb
  import shrp_pkg::*;
;
  logic clk_sys = 1'h0;
  logic rst = 1'h1;
  logic addrSelectLow = 1'h1;
  logic addrSelectHigh = 1'h0;
  logic wrReady = 1'h1;
  logic [15:0] regRdData = 16'h0000;
  logic spiClk, spiSelN, spiDataIn, spiDataOut, spiDataOutEn;
  logic sclM, sdaM, i2cClkOut, i2cClkOutEn, i2cDataOut, i2cDataOutEn;
  logic [9:0] regAddr;
  logic regRdStrobe, wrValid, sawEn;
  shrp_wr_type wrWord;
  shrp_wr_type wq[$];
  int miscompares = 0;
  int n_compared = 0;
  // wire levels: pulled up, low while any party pulls
  wire logic scl = sclM & ~i2cClkOutEn;
  wire logic sda = sdaM & ~i2cDataOutEn;
  always #20 clk_sys = ~clk_sys;
  serial_host_register_port uut (.clk_sys(clk_sys), .rst(rst),
    .spiClk(spiClk), .spiSelN(spiSelN), .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut), .spiDataOutEn(spiDataOutEn),
    .i2cClkIn(scl), .i2cClkOut(i2cClkOut), .i2cClkOutEn(i2cClkOutEn),
    .i2cDataIn(sda), .i2cDataOut(i2cDataOut),
    .i2cDataOutEn(i2cDataOutEn), .addrSelectLow(addrSelectLow),
    .addrSelectHigh(addrSelectHigh), .regAddr(regAddr),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .wrValid(wrValid), .wrReady(wrReady), .wrWord(wrWord));
  shrp_host_model host (.clk_sys(clk_sys), .spiClk(spiClk),
    .spiSelN(spiSelN), .spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
    .sclM(sclM), .sdaM(sdaM), .scl(scl), .sda(sda));
  function automatic logic [15:0] regVal(input logic [9:0] a);
    return {6'h2A, a};
  endfunction : regVal
  // register file stand-in and write sink
  always @(posedge clk_sys) begin
    if (regRdStrobe === 1'h1) regRdData <= regVal(regAddr);
    if (wrValid === 1'h1 && wrReady === 1'h1) wq.push_back(wrWord);
    if (spiDataOutEn === 1'h1) sawEn = 1'h1;
  end
  task automatic chkData(string n, logic [25:0] e, logic [25:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chkData
  task automatic chkFlag(string n, logic e, logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %b got %b", n, e, g);
    end
  endtask : chkFlag
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic spiTest;
    logic [63:0] w;
    host.spiRead({5'h1C, 1'h1, 10'h3FE}, 3, w);
    chkData("spi word 0", regVal(10'h3FE), w[63:48]);
    chkData("spi word 1", regVal(10'h3FF), w[47:32]);
    chkData("spi word 2", regVal(10'h3FF), w[31:16]);
    chkFlag("spi released", 1'h0, spiDataOutEn);
    for (int c = 0; c < 2; c++) begin
      sawEn = 1'h0;
      host.spiRead({(c == 0) ? 6'h3B : 6'h38, 10'h000}, 1, w);
      chkFlag("spi refused", 1'h0, sawEn);
    end
    $display("spi test done");
  endtask : spiTest
  // every select setting, matching and inverted address
  task automatic addrTest;
    logic [7:0] r;
    logic a;
    for (int s = 0; s < 8; s++) begin
      addrSelectHigh <= s[1];
      addrSelectLow <= s[0];
      host.cyc(8);
      host.i2cStart();
      host.i2cByte({5'h0B, s[1:0] ^ {2{s[2]}}, 1'h0}, 1'h1, r, a);
      host.i2cStop();
      chkFlag("address nack", s[2], a);
    end
    addrSelectHigh <= 1'h0;
    addrSelectLow <= 1'h1;
    $display("address test done");
  endtask : addrTest
  task automatic writeTest(logic [9:0] p, int n, logic stall);
    logic [7:0] r;
    logic a;
    int e;
    e = (p == 10'h3FF) ? 1 : n;
    wq.delete();
    wrReady <= ~stall;
    fork
      begin
        host.i2cStart();
        host.i2cByte(8'h5A, 1'h1, r, a);
        host.i2cByte({6'h3F, p[9:8]}, 1'h1, r, a);
        host.i2cByte(p[7:0], 1'h1, r, a);
        for (int j = 0; j < n; j++) begin
          host.i2cByte(8'hC0 + j[7:0], 1'h1, r, a);
          host.i2cByte(8'h35 + j[7:0], 1'h1, r, a);
        end
        host.i2cStop();
      end
      if (stall) begin
        for (int t = 0; t < 4000 && i2cClkOutEn !== 1'h1; t++)
          @(posedge clk_sys);
        chkFlag("stretch", 1'h1, i2cClkOutEn);
        chkData("held words", 26'h0, 26'(wq.size()));
        wrReady <= 1'h1;
      end
    join
    chkData("word count", 26'(e), 26'(wq.size()));
    for (int j = 0; j < e && j < wq.size(); j++)
      chkData("written word", {p + j[9:0], 8'hC0 + j[7:0],
        8'h35 + j[7:0]}, wq[j]);
    $display("write test done");
  endtask : writeTest
  task automatic readTest;
    logic [7:0] r;
    logic a;
    logic [15:0] d;
    host.i2cStart();
    host.i2cByte(8'h5A, 1'h1, r, a);
    host.i2cByte(8'h03, 1'h1, r, a);
    host.i2cByte(8'hFE, 1'h1, r, a);
    host.i2cStart();
    host.i2cByte(8'h5B, 1'h1, r, a);
    chkFlag("read ack", 1'h0, a);
    for (int j = 0; j < 4; j++) begin
      if (j == 3) begin
        host.i2cStop();
        host.i2cStart();
        host.i2cByte(8'h5B, 1'h1, r, a);
      end
      host.i2cByte(8'hFF, 1'h0, d[15:8], a);
      host.i2cByte(8'hFF, (j > 1), d[7:0], a);
      chkData("read word", regVal((j == 3) ? 10'h000 :
        ((j == 0) ? 10'h3FE : 10'h3FF)), d);
    end
    host.i2cStop();
    $display("read test done");
  endtask : readTest
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    spiTest();
    addrTest();
    writeTest(10'h100, 3, 1'h1);
    writeTest(10'h3FF, 2, 1'h0);
    readTest();
    print_verdict();
  end
  // watchdog: about five times the expected run
  initial begin
    #1600000;
    miscompares++;
    print_verdict();
  end
endmodule : serial_host_register_port_tb
